// ---- mps_strap_capture.sv ----
/*
 * Package of shared constants for the MII pin and strap block, and the
 * strap capture module that latches the pull levels on the shared pins.
 * Assumes the strap pins come from outside the clk_sys domain and that
 * reset_n is released asynchronously; capture happens after the release.
 */

// ====================================================================
// Shared constants
// ====================================================================
package mps_pkg;
  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IRQ_IDX = 8'h1B;
  localparam logic [7:0] PHY_CTRL_IDX = 8'h1F;
  localparam logic [7:0] PIN_CTRL_IDX = 8'h1D;
  localparam logic [7:0] STRAP_IDX = 8'h1E;
  // Interrupt register layout: status low byte, enables high byte
  localparam int IRQ_EN_POS = 8;
  localparam int EV_W = 4;
  localparam int EV_RX_ERR = 0;
  localparam int EV_COL = 1;
  localparam int EV_CRS = 2;
  localparam int EV_WAKE = 3;
  // Control bit positions
  localparam int IRQ_POL_BIT = 9;
  localparam int REPEATER_BIT = 0;
  localparam int WAKE_OPT2_BIT = 1;
  // Reset values
  localparam logic [EV_W-1:0] IRQ_EN_RST = 4'h0;
  localparam logic IRQ_POL_RST = 1'b0;
  localparam logic [1:0] PIN_CTRL_RST = 2'h0;
  // Strap vector positions
  localparam int STRAP_W = 6;
  localparam int ST_PORT_ISOLATION_STRAP = 0;
  localparam int ST_NAND = 1;
  localparam int ST_WAKE_EN = 2;
  localparam int ST_CFG0 = 3;
  localparam int ST_CFG1 = 4;
  localparam int ST_CFG2 = 5;
  // Cycles after release before straps are taken (sync depth plus one)
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Transmit clock timing
  localparam int CLK_NS = 40;
  localparam int TXC_HALF_NS = 160;
  localparam int TXC_HALF_CYC_I = (TXC_HALF_NS / CLK_NS) < 1 ? 1 :
                                  (TXC_HALF_NS / CLK_NS);
  localparam logic [3:0] TXC_HALF_CYC = 4'(TXC_HALF_CYC_I);
endpackage

// ====================================================================
// Strap capture
// ====================================================================
module mps_strap_capture (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [mps_pkg::STRAP_W-1:0] strap_pins,
  output logic [mps_pkg::STRAP_W-1:0] strap_reg,
  output logic done_reg
);
  logic [mps_pkg::STRAP_W-1:0] sync1_reg;
  logic [mps_pkg::STRAP_W-1:0] sync2_reg;
  logic [1:0] settle_reg;

  // Two-flop synchroniser on the raw pull levels
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= strap_pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Counts until the synchroniser holds post-release pin levels
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      settle_reg <= 2'h0;
    end else if (!done_reg) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  // straps frozen
  // Taken once at release; pin activity afterwards cannot reach them
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_reg <= '0;
      done_reg <= 1'b0;
    end else if (!done_reg && settle_reg == mps_pkg::STRAP_SETTLE) begin
      strap_reg <= sync2_reg;
      done_reg <= 1'b1;
    end
  end
endmodule

// ---- mps_pin_strap.sv ----
/*
 * MII pin sharing for pins receive error, interrupt, transmit clock,
 * transmit enable and data, collision and carrier sense, with strap
 * capture at reset release and an APB register slave.
 * Assumes MII status comes from PHY core logic on clk_sys and that the
 * board pads resolve each pin from its output and output enable.
 */

// ====================================================================
// Top module
// ====================================================================
// What this block does
// - In MII mode the receive-error pin is driven with the core's error.
// - The receive-error pin level at reset release becomes the port_isolation_strap strap.
// - The interrupt pin follows events enabled and reported in register 1Bh.
// - Bit 9 of register 1Fh sets interrupt polarity, low by default.
// - As the second wake output the pin is pulled low on a wake event.
// - The interrupt pin level at reset release becomes the NAND tree strap.
// - Transmit clock is driven normally but taken as input in repeater mode.
// - The transmit clock pin level at release becomes the wake enable strap.
// - Collision and carrier sense pins are driven from the core.
// - The collision pin level at release becomes configuration bit 0.
// - The carrier-sense pin level at release becomes configuration bit 1.
// - Strap pins stay inputs through reset and are driven only afterwards.
// - The receive-data-valid pin level at release is configuration bit 2.
module mps_pin_strap (
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PHY core side
  input wire logic core_rx_er,
  input wire logic core_col,
  input wire logic core_crs,
  input wire logic core_rx_dv,
  input wire logic core_wake_event,
  output logic core_tx_en,
  output logic [3:0] core_txd,
  output logic core_tx_strobe,
  // Strap results
  output logic port_isolation_strap,
  output logic nand_tree_strap,
  output logic wake_event_enable_strap,
  output logic cfg_strap_bit0,
  output logic cfg_strap_bit1,
  output logic cfg_strap_bit2,
  // Shared pins
  input wire logic rx_err_pin_i,
  output logic rx_err_pin_o,
  output logic rx_err_pin_oe,
  input wire logic irq_out_pin_i,
  output logic irq_out_pin_o,
  output logic irq_out_pin_oe,
  input wire logic tx_clk_pin_i,
  output logic tx_clk_pin_o,
  output logic tx_clk_pin_oe,
  input wire logic col_pin_i,
  output logic col_pin_o,
  output logic col_pin_oe,
  input wire logic crs_pin_i,
  output logic crs_pin_o,
  output logic crs_pin_oe,
  input wire logic rx_dv_pin_i,
  output logic rx_dv_pin_o,
  output logic rx_dv_pin_oe,
  input wire logic tx_en_pin,
  input wire logic [3:0] txd_pin
);
  // ==================================================================
  // Declarations
  // ==================================================================
  logic [mps_pkg::STRAP_W-1:0] strap_vec;
  logic strap_done;
  logic [mps_pkg::EV_W-1:0] irq_status_reg;
  logic [mps_pkg::EV_W-1:0] irq_status_next;
  logic [mps_pkg::EV_W-1:0] irq_en_reg;
  logic irq_pol_reg;
  logic [1:0] pin_ctrl_reg;
  logic crs_prev_reg;
  logic [mps_pkg::EV_W-1:0] events;
  logic wr_done, rd_done;
  logic irq_active, drive_ok;
  logic wake_event_out_n, wake_event_out_option_two;
  logic [5:0] tx_sync1_reg, tx_sync2_reg;
  logic txc_in_prev_reg, txc_out_reg, txc_rise;
  logic [3:0] txc_cnt_reg;

  // Byte address of a register from its index
  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = 8'(idx << 2);
  endfunction

  // ==================================================================
  // Strap capture
  // ==================================================================
  // all six straps, in strap vector order
  mps_strap_capture u_strap (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .strap_pins({rx_dv_pin_i, crs_pin_i, col_pin_i, tx_clk_pin_i,
                 irq_out_pin_i, rx_err_pin_i}),
    .strap_reg(strap_vec),
    .done_reg(strap_done)
  );

  // straps held fixed
  // Registered copies, listed in the strap vector's bit order
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {cfg_strap_bit2, cfg_strap_bit1, cfg_strap_bit0,
       wake_event_enable_strap, nand_tree_strap,
       port_isolation_strap} <= 6'h00;
    end else begin
      {cfg_strap_bit2, cfg_strap_bit1, cfg_strap_bit0,
       wake_event_enable_strap, nand_tree_strap,
       port_isolation_strap} <= strap_vec;
    end
  end

  // ==================================================================
  // APB slave
  // ==================================================================
  // Answer one cycle into the access phase, so every output is a flop
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;

  // Ready and error pulse, with read data for the access
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      case (paddr)
        reg_addr(mps_pkg::IRQ_IDX): begin
          prdata[mps_pkg::IRQ_EN_POS +: mps_pkg::EV_W] <= irq_en_reg;
          prdata[mps_pkg::EV_W-1:0] <= irq_status_next;
        end
        reg_addr(mps_pkg::PHY_CTRL_IDX): begin
          prdata[mps_pkg::IRQ_POL_BIT] <= irq_pol_reg;
        end
        reg_addr(mps_pkg::PIN_CTRL_IDX): begin
          prdata[1:0] <= pin_ctrl_reg;
        end
        reg_addr(mps_pkg::STRAP_IDX): begin
          prdata[mps_pkg::STRAP_W-1:0] <= strap_vec;
        end
        default: begin
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_en_reg <= mps_pkg::IRQ_EN_RST;
      irq_pol_reg <= mps_pkg::IRQ_POL_RST;
      pin_ctrl_reg <= mps_pkg::PIN_CTRL_RST;
    end else if (wr_done) begin
      if (paddr == reg_addr(mps_pkg::IRQ_IDX)) begin
        irq_en_reg <= pwdata[mps_pkg::IRQ_EN_POS +: mps_pkg::EV_W];
      end
      if (paddr == reg_addr(mps_pkg::PHY_CTRL_IDX)) begin
        irq_pol_reg <= pwdata[mps_pkg::IRQ_POL_BIT];
      end
      if (paddr == reg_addr(mps_pkg::PIN_CTRL_IDX)) begin
        pin_ctrl_reg <= pwdata[1:0];
      end
    end
  end

  // ==================================================================
  // Interrupt events
  // ==================================================================
  // Events from core logic, carrier reported on each change
  assign events[mps_pkg::EV_RX_ERR] = core_rx_er;
  assign events[mps_pkg::EV_COL] = core_col;
  assign events[mps_pkg::EV_CRS] = core_crs ^ crs_prev_reg;
  assign events[mps_pkg::EV_WAKE] = core_wake_event;

  // sticky status
  // A read clears, but a same-cycle event still sets the bit
  always_comb begin
    irq_status_next = irq_status_reg;
    if (rd_done && paddr == reg_addr(mps_pkg::IRQ_IDX)) begin
      irq_status_next = '0;
    end
    irq_status_next = irq_status_next | events;
  end

  // Status and carrier history
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= '0;
      crs_prev_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      crs_prev_reg <= core_crs;
    end
  end

  assign irq_active = |(irq_status_reg & irq_en_reg);
  assign wake_event_out_option_two = pin_ctrl_reg[mps_pkg::WAKE_OPT2_BIT]
                                     && wake_event_enable_strap;
  assign wake_event_out_n = !irq_status_reg[mps_pkg::EV_WAKE];

  // drive after straps
  // Isolation keeps MII outputs released as well
  assign drive_ok = strap_done && !strap_vec[mps_pkg::ST_PORT_ISOLATION_STRAP];

  // ==================================================================
  // Interrupt / wake pin (open drain)
  // ==================================================================
  // polarity on pin
  // wake pulls low
  // Open drain can only pull low; active high means low while idle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_out_pin_o <= 1'b0;
      irq_out_pin_oe <= 1'b0;
    end else begin
      irq_out_pin_o <= 1'b0;
      if (!strap_done) begin
        irq_out_pin_oe <= 1'b0;
      end else if (wake_event_out_option_two) begin
        irq_out_pin_oe <= !wake_event_out_n;
      end else begin
        irq_out_pin_oe <= irq_pol_reg ? !irq_active : irq_active;
      end
    end
  end

  // ==================================================================
  // MII status outputs
  // ==================================================================
  // receive error, collision, carrier and data valid out
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {rx_err_pin_o, col_pin_o, crs_pin_o, rx_dv_pin_o} <= 4'h0;
      {rx_err_pin_oe, col_pin_oe, crs_pin_oe, rx_dv_pin_oe} <= 4'h0;
    end else begin
      {rx_err_pin_o, col_pin_o, crs_pin_o, rx_dv_pin_o} <=
        {core_rx_er, core_col, core_crs, core_rx_dv};
      {rx_err_pin_oe, col_pin_oe, crs_pin_oe, rx_dv_pin_oe} <= {4{drive_ok}};
    end
  end

  // ==================================================================
  // Transmit clock and data
  // ==================================================================
  // Pin inputs pass two flops; bit 5 is the clock, bit 4 the enable, bits 3..0 the data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_sync1_reg <= 6'h00;
      tx_sync2_reg <= 6'h00;
      txc_in_prev_reg <= 1'b0;
    end else begin
      tx_sync1_reg <= {tx_clk_pin_i, tx_en_pin, txd_pin};
      tx_sync2_reg <= tx_sync1_reg;
      txc_in_prev_reg <= tx_sync2_reg[5];
    end
  end

  // clock divider out
  // Half period counter; it runs whenever the repeater bit is clear, even while the pin is released
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txc_cnt_reg <= 4'h0;
      txc_out_reg <= 1'b0;
    end else if (pin_ctrl_reg[mps_pkg::REPEATER_BIT]) begin
      txc_cnt_reg <= 4'h0;
      txc_out_reg <= 1'b0;
    end else if (txc_cnt_reg == mps_pkg::TXC_HALF_CYC - 4'h1) begin
      txc_cnt_reg <= 4'h0;
      txc_out_reg <= !txc_out_reg;
    end else begin
      txc_cnt_reg <= txc_cnt_reg + 4'h1;
    end
  end

  // repeater clock input
  // Repeater mode samples on the far clock's rise, else on our own
  assign txc_rise = pin_ctrl_reg[mps_pkg::REPEATER_BIT]
                    ? (tx_sync2_reg[5] && !txc_in_prev_reg)
                    : (!txc_out_reg && !pin_ctrl_reg[mps_pkg::REPEATER_BIT]
                       && txc_cnt_reg == mps_pkg::TXC_HALF_CYC - 4'h1);

  // Transmit clock pin drive
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_clk_pin_o <= 1'b0;
      tx_clk_pin_oe <= 1'b0;
    end else begin
      tx_clk_pin_o <= txc_out_reg;
      tx_clk_pin_oe <= drive_ok && !pin_ctrl_reg[mps_pkg::REPEATER_BIT];
    end
  end

  // MAC transmit inputs
  // Nibble taken at each transmit clock rise, bit 0 lowest
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_tx_en <= 1'b0;
      core_txd <= 4'h0;
      core_tx_strobe <= 1'b0;
    end else begin
      core_tx_strobe <= txc_rise && strap_done;
      if (txc_rise && strap_done) begin
        core_tx_en <= tx_sync2_reg[4];
        core_txd <= tx_sync2_reg[3:0];
      end
    end
  end
endmodule

// ---- mps_pin_strap_chk.sv ----
/*
 * Checker for the MII pin and strap block, bound to its top module.
 * Assumes pins are resolved by the bench and clk_sys runs freely.
 */
module mps_pin_strap_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic core_rx_er,
  input wire logic core_col,
  input wire logic core_crs,
  input wire logic core_tx_strobe,
  input wire logic port_isolation_strap,
  input wire logic nand_tree_strap,
  input wire logic wake_event_enable_strap,
  input wire logic cfg_strap_bit0,
  input wire logic cfg_strap_bit1,
  input wire logic cfg_strap_bit2,
  input wire logic rx_err_pin_i,
  input wire logic rx_err_pin_o,
  input wire logic rx_err_pin_oe,
  input wire logic irq_out_pin_i,
  input wire logic irq_out_pin_o,
  input wire logic irq_out_pin_oe,
  input wire logic tx_clk_pin_i,
  input wire logic tx_clk_pin_o,
  input wire logic tx_clk_pin_oe,
  input wire logic col_pin_i,
  input wire logic col_pin_o,
  input wire logic col_pin_oe,
  input wire logic crs_pin_i,
  input wire logic crs_pin_o,
  input wire logic crs_pin_oe,
  input wire logic rx_dv_pin_i
);
  logic [3:0] rel_cnt_reg;
  logic [5:0] straps;
  logic [5:0] pins;

  // ==================================================================
  // Helpers
  // ==================================================================
  // Edges since release; saturates so it never wraps into the window
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rel_cnt_reg <= 4'h0;
    end else if (rel_cnt_reg != 4'hF) begin
      rel_cnt_reg <= rel_cnt_reg + 4'h1;
    end
  end
  // Strap results and pin levels in the same bit order
  assign straps = {cfg_strap_bit2, cfg_strap_bit1, cfg_strap_bit0,
    wake_event_enable_strap, nand_tree_strap, port_isolation_strap};
  assign pins = {rx_dv_pin_i, crs_pin_i, col_pin_i, tx_clk_pin_i,
    irq_out_pin_i, rx_err_pin_i};

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // ==================================================================
  // Properties
  // ==================================================================
  // Status pins mirror the core one cycle late while driven
  a_rxer_follow: assert property (
    rx_err_pin_oe |-> rx_err_pin_o == $past(core_rx_er))
    else $error("receive error pin does not follow core");
  a_col_follow: assert property (
    col_pin_oe |-> col_pin_o == $past(core_col))
    else $error("collision pin does not follow core");
  a_crs_follow: assert property (
    crs_pin_oe |-> crs_pin_o == $past(core_crs))
    else $error("carrier pin does not follow core");
  // Pins still released on the first edge after release
  a_oe_released: assert property (
    $rose(reset_n) |-> !(rx_err_pin_oe | irq_out_pin_oe |
      tx_clk_pin_oe | col_pin_oe | crs_pin_oe))
    else $error("pin driven before straps taken");
  // Straps equal the pull levels seen early after release
  a_strap_take: assert property (
    rel_cnt_reg == 4'h8 |-> straps == $past(pins, 6))
    else $error("strap value differs from pin level");
  a_strap_hold: assert property (
    rel_cnt_reg > 4'h6 |-> $stable(straps))
    else $error("strap changed after capture");
  a_irq_drain: assert property (
    !irq_out_pin_o)
    else $error("open drain pin driven high");
  a_txc_half: assert property (
    $fell(tx_clk_pin_o) && tx_clk_pin_oe |->
      $past(tx_clk_pin_o, 4) && !$past(tx_clk_pin_o, 5))
    else $error("transmit clock high phase wrong");
  a_strobe_one: assert property (
    core_tx_strobe |=> !core_tx_strobe)
    else $error("nibble strobe longer than one cycle");
  a_apb_answer: assert property (
    psel && $rose(penable) |=> pready)
    else $error("register access not answered in time");
endmodule

// ---- mps_mac_model.sv ----
/*
 * MAC side of the transmit path: sends a counting nibble stream and
 * can supply the transmit clock in repeater use.
 * Assumes tx_clk_line is the resolved transmit clock pin.
 */
module mps_mac_model (
  input wire logic tx_clk_line,
  input wire logic rep_en,
  output logic rep_clk,
  output logic tx_en_pin,
  output logic [3:0] txd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] nib_reg;

  // far end clock
  // Runs only while enabled; odd offset keeps it off the system phase
  initial begin
    rep_clk = 1'b0;
    #7;
    forever begin
      #160;
      if (rep_en) begin
        rep_clk = ~rep_clk;
      end
    end
  end
  // nibble on pins
  // Changed on the falling edge so it is settled at the rising one
  initial begin
    nib_reg = 4'h0;
    tx_en_pin = 1'b0;
    txd_pin = 4'h0;
    forever begin
      @(negedge tx_clk_line);
      tx_en_pin <= 1'b1;
      txd_pin <= nib_reg;
      nib_reg <= nib_reg + 4'h1;
    end
  end
endmodule

// ---- mps_pin_strap_tb_top.sv ----
/*
 * Self-checking bench for the MII pin and strap block.
 * Assumes the checker and MAC model files are compiled first.
 */
module mps_pin_strap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic core_rx_er, core_col, core_crs, core_rx_dv, core_wake_event;
  logic core_tx_en, core_tx_strobe, rep_en, rep_clk, tx_en_pin;
  logic [3:0] core_txd, txd_pin, d0, d1, mii_o, mii_oe;
  logic [5:0] pull, straps;
  logic rx_err_pin_i, rx_err_pin_o, rx_err_pin_oe;
  logic irq_out_pin_i, irq_out_pin_o, irq_out_pin_oe;
  logic tx_clk_pin_i, tx_clk_pin_o, tx_clk_pin_oe;
  logic col_pin_i, col_pin_o, col_pin_oe, crs_pin_i, crs_pin_o;
  logic crs_pin_oe, rx_dv_pin_i, rx_dv_pin_o, rx_dv_pin_oe;
  logic port_isolation_strap, nand_tree_strap, wake_event_enable_strap;
  logic cfg_strap_bit0, cfg_strap_bit1, cfg_strap_bit2;
  int mismatches, samples_checked;

  // Released pins fall to the board pull; the transmit clock takes rep_clk when rep_en is set
  assign rx_err_pin_i = rx_err_pin_oe ? rx_err_pin_o : pull[0];
  assign irq_out_pin_i = irq_out_pin_oe ? irq_out_pin_o : pull[1];
  assign tx_clk_pin_i = tx_clk_pin_oe ? tx_clk_pin_o :
    (rep_en ? rep_clk : pull[2]);
  assign col_pin_i = col_pin_oe ? col_pin_o : pull[3];
  assign crs_pin_i = crs_pin_oe ? crs_pin_o : pull[4];
  assign rx_dv_pin_i = rx_dv_pin_oe ? rx_dv_pin_o : pull[5];
  assign straps = {cfg_strap_bit2, cfg_strap_bit1, cfg_strap_bit0,
    wake_event_enable_strap, nand_tree_strap, port_isolation_strap};
  assign mii_o = {rx_dv_pin_o, crs_pin_o, col_pin_o, rx_err_pin_o};
  assign mii_oe = {rx_dv_pin_oe, crs_pin_oe, col_pin_oe, rx_err_pin_oe};

  mps_pin_strap dut (
    .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .core_rx_er, .core_col, .core_crs,
    .core_rx_dv, .core_wake_event, .core_tx_en, .core_txd,
    .core_tx_strobe, .port_isolation_strap, .nand_tree_strap,
    .wake_event_enable_strap, .cfg_strap_bit0, .cfg_strap_bit1,
    .cfg_strap_bit2, .rx_err_pin_i, .rx_err_pin_o, .rx_err_pin_oe,
    .irq_out_pin_i, .irq_out_pin_o, .irq_out_pin_oe, .tx_clk_pin_i,
    .tx_clk_pin_o, .tx_clk_pin_oe, .col_pin_i, .col_pin_o, .col_pin_oe,
    .crs_pin_i, .crs_pin_o, .crs_pin_oe, .rx_dv_pin_i, .rx_dv_pin_o,
    .rx_dv_pin_oe, .tx_en_pin, .txd_pin
  );
  mps_mac_model mac (
    .tx_clk_line(tx_clk_pin_i), .rep_en, .rep_clk, .tx_en_pin, .txd_pin
  );

  // 25 MHz system clock
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  // ==================================================================
  // Shared tasks
  // ==================================================================
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; a hung wait is ended only by the watchdog
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Pulse core events for one cycle, then let the pin settle
  task automatic ev(input logic [2:0] m);
    {core_wake_event, core_col, core_rx_er} <= m;
    @(posedge clk_sys);
    {core_wake_event, core_col, core_rx_er} <= 3'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic wait_st();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (core_tx_strobe !== 1'b1 && n < 40);
    d1 = core_txd;
  endtask

  // ==================================================================
  // Scenarios
  // ==================================================================
  task automatic rst(input logic [5:0] p);
    pull <= p;
    reset_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("oe in reset", 0, {mii_oe, irq_out_pin_oe, tx_clk_pin_oe});
    reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("straps", p, straps);
    chk("mii oe", p[0] ? 4'h0 : 4'hF, mii_oe);
    apb(1'b0, 8'h78, 0);
    chk("strap reg", p, q);
  endtask
  task automatic t_apb();
    apb(1'b0, 8'h7C, 0);
    chk("polarity reset", 0, q[9]);
    apb(1'b0, 8'h00, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, q);
    apb(1'b1, 8'h78, 32'h3F);
    apb(1'b0, 8'h78, 0);
    chk("strap read only", 32'h14, q);
  endtask
  task automatic t_mii();
    logic [3:0] v [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
    foreach (v[i]) begin
      {core_rx_dv, core_crs, core_col, core_rx_er} <= v[i];
      repeat (2) @(posedge clk_sys);
      chk("mii out", v[i], mii_o);
    end
  endtask
  task automatic t_irq();
    apb(1'b1, 8'h6C, 32'hF00);
    apb(1'b0, 8'h6C, 0);
    ev(3'h2);
    chk("irq active low", 1, irq_out_pin_oe);
    apb(1'b0, 8'h6C, 0);
    chk("irq status", 32'hF02, q);
    @(posedge clk_sys);
    chk("irq cleared", 0, irq_out_pin_oe);
    apb(1'b1, 8'h7C, 32'h200);
    repeat (2) @(posedge clk_sys);
    chk("irq high idle", 1, irq_out_pin_oe);
    ev(3'h1);
    chk("irq high active", 0, irq_out_pin_oe);
    apb(1'b0, 8'h6C, 0);
    chk("irq status", 32'hF01, q);
    apb(1'b1, 8'h7C, 0);
    apb(1'b1, 8'h6C, 0);
    ev(3'h2);
    chk("irq masked", 0, irq_out_pin_oe);
    apb(1'b0, 8'h6C, 0);
    chk("masked status", 32'h2, q);
  endtask
  task automatic t_wake();
    apb(1'b1, 8'h6C, 32'h800);
    apb(1'b1, 8'h74, 32'h2);
    ev(3'h4);
    chk("wake out", 1, irq_out_pin_oe);
    apb(1'b0, 8'h6C, 0);
    chk("wake status", 32'h808, q);
    @(posedge clk_sys);
    chk("wake cleared", 0, irq_out_pin_oe);
    apb(1'b1, 8'h74, 0);
  endtask
  task automatic t_tx(input logic rep);
    if (rep) begin
      apb(1'b1, 8'h74, 32'h1);
      rep_en <= 1'b1;
    end
    repeat (20) @(posedge clk_sys);
    chk("txc drive", !rep, tx_clk_pin_oe);
    for (int n = 0; n < 4; n++) begin
      d0 = d1;
      wait_st();
      chk("tx strobe", 1, core_tx_strobe);
      chk("tx enable", 1, core_tx_en);
      if (n > 0) chk("nibble", 4'(d0 + 4'h1), d1);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence; first reset uses port_isolation_strap, second drives the pins
  initial begin
    mismatches = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {core_rx_er, core_col, core_crs, core_rx_dv, core_wake_event} = '0;
    pull = 6'h2B;
    rep_en = 1'b0;
    rst(6'h2B);
    rst(6'h14);
    t_apb();
    t_mii();
    t_irq();
    t_wake();
    t_tx(1'b0);
    t_tx(1'b1);
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
endmodule

bind mps_pin_strap mps_pin_strap_chk u_chk (
  .clk_sys, .reset_n, .psel, .penable, .pready, .core_rx_er, .core_col,
  .core_crs, .core_tx_strobe, .port_isolation_strap, .nand_tree_strap,
  .wake_event_enable_strap, .cfg_strap_bit0, .cfg_strap_bit1,
  .cfg_strap_bit2, .rx_err_pin_i, .rx_err_pin_o, .rx_err_pin_oe,
  .irq_out_pin_i, .irq_out_pin_o, .irq_out_pin_oe, .tx_clk_pin_i,
  .tx_clk_pin_o, .tx_clk_pin_oe, .col_pin_i, .col_pin_o, .col_pin_oe,
  .crs_pin_i, .crs_pin_o, .crs_pin_oe, .rx_dv_pin_i
);
